//--- ldhsp_defs.svh
// ldhsp_defs.svh: constants for the display driver host serial front end
// assumes inclusion by the design modules
`ifndef LDHSP_DEFS_SVH
`define LDHSP_DEFS_SVH
`define LDHSP_I2C_ADDR_FIXED 6'h1c
`define LDHSP_SPI_SUBADDR 2'h1
`define LDHSP_CTRL_MORE_BIT 7
`define LDHSP_CTRL_TARGET_BIT 6
`define LDHSP_SPI_DIR_BIT 7
`define LDHSP_BIT_LAST 3'h7
`define LDHSP_BIT_FIRST 3'h0
`endif

//--- ldhsp_pkg.sv
// ldhsp_pkg.sv: types shared by the serial front end modules
// assumes ldhsp_defs.svh is on the include path
package ldhsp_pkg;
	typedef enum logic [1:0] {
		LDHSP_BYTE_ADDR,
		LDHSP_BYTE_CTRL,
		LDHSP_BYTE_DATA,
		LDHSP_BYTE_SKIP
	} ldhsp_byte_role_t;
endpackage : ldhsp_pkg

//--- ldhsp_sync.sv
// ldhsp_sync.sv: two flip-flop synchroniser with edge detection on the clean side
// assumes the input is asynchronous to sys_clk_i
`timescale 1ns/10ps
`include "ldhsp_defs.svh"
module ldhsp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	input wire logic [WIDTH-1:0] init_i,
	output logic [WIDTH-1:0] level_o,
	output logic [WIDTH-1:0] rise_o,
	output logic [WIDTH-1:0] fall_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] prev_q;
	logic init_done_q;
	// first stage is read only by the second stage
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	// previous value seeded from the idle level, but the zero-reset stages still fake a fall and then a rise after release
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_q <= '0;
			init_done_q <= 1'b0;
		end else begin
			init_done_q <= 1'b1;
			prev_q <= init_done_q ? sync_q : init_i;
		end
	end
	assign level_o = init_done_q ? sync_q : init_i;
	assign rise_o = init_done_q ? (sync_q & ~prev_q) : '0;
	assign fall_o = init_done_q ? (~sync_q & prev_q) : '0;
endmodule : ldhsp_sync

//--- ldhsp_byte_router.sv
// ldhsp_byte_router.sv: control byte interpreter shared by both serial variants
// assumes one-cycle strobes from the receiving front end on sys_clk_i
`timescale 1ns/10ps
`include "ldhsp_defs.svh"
module ldhsp_byte_router
	import ldhsp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	output logic cmd_valid_o,
	output logic [7:0] cmd_byte_o,
	output logic ram_valid_o,
	output logic [7:0] ram_byte_o
);
	ldhsp_byte_role_t role_q;
	logic more_q;
	logic target_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			role_q <= LDHSP_BYTE_CTRL;
			more_q <= 1'b0;
			target_q <= 1'b0;
		end else if (start_i) begin
			role_q <= LDHSP_BYTE_CTRL;
		end else if (byte_valid_i) begin
			case (role_q)
				LDHSP_BYTE_CTRL: begin
					more_q <= byte_i[`LDHSP_CTRL_MORE_BIT];
					target_q <= byte_i[`LDHSP_CTRL_TARGET_BIT];
					role_q <= LDHSP_BYTE_DATA;
				end
				LDHSP_BYTE_DATA: begin
					// with more set, another control byte follows this data byte
					role_q <= more_q ? LDHSP_BYTE_CTRL : LDHSP_BYTE_DATA;
				end
				default: begin
					role_q <= LDHSP_BYTE_CTRL;
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_valid_o <= 1'b0;
			ram_valid_o <= 1'b0;
			cmd_byte_o <= 8'h00;
			ram_byte_o <= 8'h00;
		end else begin
			cmd_valid_o <= byte_valid_i && !start_i && role_q == LDHSP_BYTE_DATA && !target_q;
			ram_valid_o <= byte_valid_i && !start_i && role_q == LDHSP_BYTE_DATA && target_q;
			if (byte_valid_i) begin
				cmd_byte_o <= byte_i;
				ram_byte_o <= byte_i;
			end
		end
	end
	// a data byte goes to exactly one destination
	chk_route_exclusive: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) !(cmd_valid_o && ram_valid_o)) else $error("byte routed to both");
	chk_ctrl_no_route: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) (byte_valid_i && !start_i && role_q == LDHSP_BYTE_CTRL) |=> !(cmd_valid_o || ram_valid_o)) else $error("control byte routed");
endmodule : ldhsp_byte_router

//--- ldhsp_serial_port.sv
// ldhsp_serial_port.sv: host serial front end, I2C slave receiver and transmitter or three-wire SPI
// assumes pins are asynchronous to sys_clk_i; serial clock far slower than sys_clk_i
`timescale 1ns/10ps
`include "ldhsp_defs.svh"
module ldhsp_serial_port
	import ldhsp_pkg::*;
#(
	parameter bit SPI_MODE = 1'b0
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic select_n_i,
	input wire logic address_strap_pin_i,
	input wire logic [7:0] temperature_readout_byte_i,
	output logic cmd_valid_o,
	output logic [7:0] cmd_byte_o,
	output logic ram_valid_o,
	output logic [7:0] ram_byte_o,
	output logic busy_o
);
	import ldhsp_pkg::*;

	typedef enum logic [2:0] {
		LDHSP_IDLE,
		LDHSP_RECV,
		LDHSP_ACK,
		LDHSP_SEND,
		LDHSP_WAIT_NACK,
		LDHSP_IGNORE
	} ldhsp_state_t;

	logic scl_lvl, scl_rise, scl_fall;
	logic sda_lvl, sda_rise, sda_fall;
	logic sel_lvl, sel_rise, sel_fall;
	logic strap_q;
	logic [7:0] temp_q;
	ldhsp_state_t state_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic first_q;
	logic read_q;
	logic drive_q;
	logic out_q;
	logic skip_q;
	logic byte_valid;
	logic start_ev;
	logic stop_ev;
	logic spi_rst;
	logic [7:0] rx_byte;

	ldhsp_sync #(.WIDTH(3)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({scl_i, sda_i, select_n_i}),
		.init_i(3'h7),
		.level_o({scl_lvl, sda_lvl, sel_lvl}),
		.rise_o({scl_rise, sda_rise, sel_rise}),
		.fall_o({scl_fall, sda_fall, sel_fall})
	);

	// strap and temperature are quasi static; caught by a clocked process, never at reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_q <= 1'b0;
		end else begin
			strap_q <= address_strap_pin_i;
		end
	end
	// temperature is frozen when a read begins so the byte is self consistent
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			temp_q <= 8'h00;
		end else if (state_q != LDHSP_SEND) begin
			temp_q <= temperature_readout_byte_i;
		end
	end

	// i2c start and stop: data edges while clock high; unused in spi mode
	assign start_ev = !SPI_MODE && scl_lvl && sda_fall;
	assign stop_ev = !SPI_MODE && scl_lvl && sda_rise;
	assign spi_rst = SPI_MODE && sel_lvl;
	assign rx_byte = {shift_q[6:0], sda_lvl};

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= LDHSP_IDLE;
			bit_q <= `LDHSP_BIT_FIRST;
			shift_q <= 8'h00;
			first_q <= 1'b1;
			read_q <= 1'b0;
		end else if (spi_rst) begin
			state_q <= LDHSP_IDLE;
			bit_q <= `LDHSP_BIT_FIRST;
			first_q <= 1'b1;
			read_q <= 1'b0;
		end else if (SPI_MODE && state_q == LDHSP_IDLE) begin
			state_q <= LDHSP_RECV;
			bit_q <= `LDHSP_BIT_FIRST;
			first_q <= 1'b1;
		end else if (start_ev) begin
			state_q <= LDHSP_RECV;
			bit_q <= `LDHSP_BIT_FIRST;
			first_q <= 1'b1;
			read_q <= 1'b0;
		end else if (stop_ev) begin
			state_q <= LDHSP_IDLE;
		end else begin
			case (state_q)
				LDHSP_RECV: begin
					if (scl_rise) begin
						shift_q <= rx_byte;
						bit_q <= bit_q + 3'h1;
						if (bit_q == `LDHSP_BIT_LAST) begin
							if (SPI_MODE && first_q) begin
								first_q <= 1'b0;
								read_q <= rx_byte[`LDHSP_SPI_DIR_BIT];
								if (rx_byte[6:5] != `LDHSP_SPI_SUBADDR) begin
									state_q <= LDHSP_IGNORE;
								end else if (rx_byte[`LDHSP_SPI_DIR_BIT]) begin
									state_q <= LDHSP_SEND;
								end
							end else if (!SPI_MODE && first_q &&
								rx_byte[7:1] != {`LDHSP_I2C_ADDR_FIXED, strap_q}) begin
								state_q <= LDHSP_IGNORE;
							end else begin
								if (first_q) begin
									read_q <= rx_byte[0];
								end
								first_q <= 1'b0;
								state_q <= SPI_MODE ? LDHSP_RECV : LDHSP_ACK;
							end
						end
					end
				end
				LDHSP_ACK: begin
					// ack lasts one full clock pulse, ended by its falling edge
					if (scl_fall && drive_q) begin
						state_q <= read_q ? LDHSP_SEND : LDHSP_RECV;
						bit_q <= `LDHSP_BIT_FIRST;
					end
				end
				LDHSP_SEND: begin
					// bit_q is the index, msb first, of the bit now on the line
					if (scl_fall && drive_q && !skip_q) begin
						if (bit_q == `LDHSP_BIT_LAST) begin
							// spi holds the last bit until select rises
							state_q <= SPI_MODE ? LDHSP_SEND : LDHSP_WAIT_NACK;
						end else begin
							bit_q <= bit_q + 3'h1;
						end
					end
				end
				LDHSP_WAIT_NACK: begin
					state_q <= LDHSP_WAIT_NACK;
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// pin driver: acks on i2c falling edges, data shifted out on falling edges
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_q <= 1'b0;
			out_q <= 1'b1;
			skip_q <= 1'b0;
		end else if (spi_rst || start_ev || stop_ev) begin
			drive_q <= 1'b0;
			out_q <= 1'b1;
			skip_q <= 1'b0;
		end else if (SPI_MODE && state_q == LDHSP_SEND && !drive_q) begin
			// the msb goes out at once; the subaddress byte's own falling edge is not a shift
			drive_q <= 1'b1;
			out_q <= temp_q[`LDHSP_BIT_LAST];
			skip_q <= 1'b1;
		end else if (scl_fall) begin
			skip_q <= 1'b0;
			if (state_q == LDHSP_ACK && !drive_q) begin
				drive_q <= 1'b1;
				out_q <= 1'b0;
			end else if (state_q == LDHSP_ACK && read_q) begin
				out_q <= temp_q[`LDHSP_BIT_LAST];
			end else if (state_q == LDHSP_SEND && !skip_q) begin
				if (bit_q == `LDHSP_BIT_LAST) begin
					drive_q <= SPI_MODE;
				end else begin
					out_q <= temp_q[`LDHSP_BIT_LAST - bit_q - 3'h1];
				end
			end else if (state_q != LDHSP_SEND) begin
				drive_q <= 1'b0;
				out_q <= 1'b1;
			end
		end
	end

	assign sda_o = out_q;
	assign sda_oe_n_o = !drive_q;
	assign busy_o = state_q != LDHSP_IDLE;
	assign byte_valid = state_q == LDHSP_RECV && scl_rise && bit_q == `LDHSP_BIT_LAST && !first_q
		&& !spi_rst && !start_ev && !stop_ev;

	ldhsp_byte_router u_router (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(first_q),
		.byte_valid_i(byte_valid),
		.byte_i(rx_byte),
		.cmd_valid_o(cmd_valid_o),
		.cmd_byte_o(cmd_byte_o),
		.ram_valid_o(ram_valid_o),
		.ram_byte_o(ram_byte_o)
	);

	chk_spi_held_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(SPI_MODE && sel_lvl) |=> (state_q == LDHSP_IDLE && !drive_q)) else $error("spi not reset");
	chk_spi_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(SPI_MODE && sel_rise) |=> sda_oe_n_o) else $error("spi line not released");
	chk_ignore_silent: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == LDHSP_IGNORE) |-> (sda_oe_n_o && !cmd_valid_o && !ram_valid_o)) else $error("ignored transfer active");
	chk_ignore_until_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == LDHSP_IGNORE && !start_ev && !stop_ev && !spi_rst) |=> state_q == LDHSP_IGNORE) else $error("left ignore early");
	chk_ack_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_q == LDHSP_ACK && !sda_oe_n_o) |-> !sda_o) else $error("ack not low");
	chk_drive_owner: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!sda_oe_n_o |-> (state_q inside {LDHSP_ACK, LDHSP_SEND, LDHSP_RECV})) else $error("line driven outside ack or send");
	chk_write_on_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		byte_valid |-> scl_rise) else $error("byte taken off rising edge");
	chk_spi_read_drive: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(SPI_MODE && state_q == LDHSP_SEND && !sel_lvl) |-> ##[0:2] !sda_oe_n_o) else $error("spi read not driven");
endmodule : ldhsp_serial_port

//--- ldhsp_host_model.sv
// ldhsp_host_model.sv: bus master model driving the serial front end
// assumes pins change on falling sys_clk edges; serial clock half period is four cycles
`timescale 1ns/10ps
module ldhsp_host_model (
	input wire logic sys_clk_i,
	input wire logic line_i,
	output logic scl_o,
	output logic sda_o,
	output logic sda_en_o,
	output logic select_n_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		sda_en_o = 1'b1;
		select_n_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : tick
	// data moves only while the clock is low, so no false start or stop
	task automatic bit_io(input logic d, output logic s);
		tick(2);
		sda_o = d;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		s = line_i;
		tick(2);
		scl_o = 1'b0;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
	endtask : byte_io
	task automatic start();
		tick(4);
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b0;
	endtask : start
	task automatic stop();
		tick(2);
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b1;
		tick(4);
	endtask : stop
	task automatic spi_begin();
		scl_o = 1'b0;
		tick(2);
		select_n_o = 1'b0;
		tick(2);
	endtask : spi_begin
	// select always returns high between accesses so the port resets
	task automatic spi_end();
		tick(2);
		select_n_o = 1'b1;
	endtask : spi_end
endmodule : ldhsp_host_model

//--- tb_top.sv
// tb_top.sv: self-checking bench, one I2C and one SPI front end behind one host model
// assumes the design files and the host model are compiled before it
`timescale 1ns/10ps
module tb_top;
	import ldhsp_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic strap = 1'b1;
	logic [7:0] temp = 8'h96;
	logic scl, h_d, h_en, cs_n, spi_last, i2c_line, spi_line;
	logic i_sda, i_oe_n, i_cv, i_rv, i_busy, s_sda, s_oe_n, s_cv, s_rv;
	logic [7:0] i_cb, i_rb, s_cb, s_rb, cmd_b, ram_b;
	int fails = 0;
	int comparisons = 0;
	int n_cmd = 0;
	int n_ram = 0;
	int e_cmd = 0;
	int e_ram = 0;
	int cyc = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	// pull-up on the I2C line; an undriven SPI line toggles, never holds its value
	assign i2c_line = h_d & (i_oe_n | i_sda);
	assign spi_line = !s_oe_n ? s_sda : (h_en ? h_d : ~spi_last);
	always @(posedge sys_clk_i) spi_last <= spi_line;
	ldhsp_host_model host (.sys_clk_i(sys_clk_i), .line_i(cs_n ? i2c_line : spi_line),
		.scl_o(scl), .sda_o(h_d), .sda_en_o(h_en), .select_n_o(cs_n));
	ldhsp_serial_port #(.SPI_MODE(1'b0)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.scl_i(scl), .sda_i(i2c_line), .sda_o(i_sda), .sda_oe_n_o(i_oe_n), .select_n_i(1'b1),
		.address_strap_pin_i(strap), .temperature_readout_byte_i(temp), .cmd_valid_o(i_cv),
		.cmd_byte_o(i_cb), .ram_valid_o(i_rv), .ram_byte_o(i_rb), .busy_o(i_busy));
	ldhsp_serial_port #(.SPI_MODE(1'b1)) dut_spi (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.scl_i(scl), .sda_i(spi_line), .sda_o(s_sda), .sda_oe_n_o(s_oe_n), .select_n_i(cs_n),
		.address_strap_pin_i(strap), .temperature_readout_byte_i(temp), .cmd_valid_o(s_cv),
		.cmd_byte_o(s_cb), .ram_valid_o(s_rv), .ram_byte_o(s_rb), .busy_o());
	always @(posedge sys_clk_i) begin
		cyc++;
		if (i_cv === 1'b1 || s_cv === 1'b1) begin
			n_cmd++;
			cmd_b = i_cv === 1'b1 ? i_cb : s_cb;
		end
		if (i_rv === 1'b1 || s_rv === 1'b1) begin
			n_ram++;
			ram_b = i_rv === 1'b1 ? i_rb : s_rb;
		end
		if (cyc == 30000) begin
			fails++;
			complete_run();
		end
	end
	task automatic chk_bit(input string n, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %b seen %b", n, e, g);
		end
	endtask : chk_bit
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk_byte
	task automatic counts();
		chk_byte("cmd count", e_cmd[7:0], n_cmd[7:0]);
		chk_byte("ram count", e_ram[7:0], n_ram[7:0]);
	endtask : counts
	task automatic rx(input logic ram, input logic [7:0] b);
		host.tick(3);
		if (ram) begin
			e_ram++;
			chk_byte("ram byte", b, ram_b);
		end else begin
			e_cmd++;
			chk_byte("cmd byte", b, cmd_b);
		end
		counts();
	endtask : rx
	task automatic i2c_wr(input logic [7:0] b, input logic ack);
		logic [7:0] r;
		logic s;
		host.byte_io(b, r);
		host.bit_io(1'b1, s);
		chk_bit("ack", ack, ~s);
	endtask : i2c_wr
	task automatic t_i2c_write();
		strap = 1'b1;
		host.start();
		i2c_wr({6'h1c, 1'b1, 1'b0}, 1'b1);
		i2c_wr(8'hc0, 1'b1);
		i2c_wr(8'ha5, 1'b1);
		rx(1'b1, 8'ha5);
		i2c_wr(8'h00, 1'b1);
		i2c_wr(8'h3c, 1'b1);
		rx(1'b0, 8'h3c);
		i2c_wr(8'h5a, 1'b1);
		rx(1'b0, 8'h5a);
		host.stop();
		chk_bit("busy", 1'b0, i_busy);
		$display("test i2c write done");
	endtask : t_i2c_write
	task automatic t_i2c_foreign();
		strap = 1'b0;
		host.start();
		i2c_wr({6'h1c, 1'b1, 1'b0}, 1'b0);
		i2c_wr(8'h40, 1'b0);
		i2c_wr(8'h11, 1'b0);
		host.stop();
		counts();
		$display("test i2c foreign address done");
	endtask : t_i2c_foreign
	task automatic t_i2c_read();
		logic [7:0] r;
		logic s;
		host.start();
		i2c_wr({6'h1c, 1'b0, 1'b1}, 1'b1);
		host.byte_io(8'hff, r);
		chk_byte("temperature", 8'h96, r);
		host.bit_io(1'b1, s);
		chk_bit("sda released", 1'b1, i_oe_n);
		host.stop();
		counts();
		$display("test i2c read done");
	endtask : t_i2c_read
	task automatic t_spi_write();
		logic [7:0] r;
		logic s;
		host.spi_begin();
		repeat (4) host.bit_io(1'b1, s);
		host.spi_end();
		host.spi_begin();
		host.byte_io(8'h20, r);
		host.byte_io(8'h40, r);
		host.byte_io(8'h81, r);
		rx(1'b1, 8'h81);
		host.byte_io(8'h7e, r);
		rx(1'b1, 8'h7e);
		host.spi_end();
		$display("test spi write done");
	endtask : t_spi_write
	task automatic t_spi_bad();
		logic [7:0] codes [3] = '{8'h60, 8'h00, 8'h40};
		logic [7:0] r;
		foreach (codes[i]) begin
			host.spi_begin();
			host.byte_io(codes[i], r);
			host.byte_io(8'h40, r);
			host.byte_io(8'h99, r);
			host.spi_end();
			counts();
		end
		$display("test spi bad subaddress done");
	endtask : t_spi_bad
	task automatic t_spi_read();
		logic [7:0] r;
		temp = 8'h3c;
		// temperature stays at 8'h3c; it is fetched twice, with select high between the reads
		repeat (2) begin
			host.spi_begin();
			host.byte_io(8'ha0, r);
			h_en = 1'b0;
			host.byte_io(8'h00, r);
			chk_bit("sda driven", 1'b0, s_oe_n);
			chk_byte("temperature", 8'h3c, r);
			host.spi_end();
			host.tick(3);
			chk_bit("sda released", 1'b1, s_oe_n);
			h_en = 1'b1;
		end
		counts();
		$display("test spi read done");
	endtask : t_spi_read
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (3) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		t_i2c_write();
		t_i2c_foreign();
		t_i2c_read();
		t_spi_write();
		t_spi_bad();
		t_spi_read();
		complete_run();
	end
endmodule : tb_top
